// file: hw/cpu_register_flags.sv
/*
  Dedicated CPU registers, status word, flag update logic, interrupt
  threshold check, address region decode and an APB register window.
  Assumes ALU, sequencer and interrupt arbiter on the same clock.
*/
`timescale 1ns/1ns
module cpu_register_flags (
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // ALU operation
  input  wire logic        alu_valid_in,
  input  wire logic [2:0]  alu_op_in,
  input  wire logic        alu_word_in,
  // Sequencer register write and program counter step
  input  wire logic        seq_wr_in,
  input  wire logic [2:0]  seq_sel_in,
  input  wire logic [15:0] seq_wdata_in,
  input  wire logic        pc_inc_in,
  // Register operand access
  input  wire logic [2:0]  gp_idx_in,
  input  wire logic        gp_we_in,
  input  wire logic [7:0]  gp_wdata_in,
  output logic      [7:0]  gp_rdata_out,
  // Interrupt request check
  input  wire logic        irq_req_in,
  input  wire logic [1:0]  irq_level_in,
  output logic             irq_accept_out,
  // Address region decode
  input  wire logic [15:0] mem_addr_in,
  output logic      [1:0]  mem_region_out,
  // Register views
  output logic      [15:0] pc_out,
  output logic      [15:0] acc_out,
  output logic      [15:0] program_status_word_out
);

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] index_offset_reg;
    logic [15:0] extra_pointer;
    logic [15:0] stack;
    logic [7:0]  bank_select_pointer;
    logic [7:0]  condition_flags_byte;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_accept;
    logic [1:0]  region;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;

  gp_bank_if bank_port ();

  gp_bank_ram #(
    .RAM_BYTES (cpu_regs_pkg::RAM_BYTES)
  ) u_bank (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .port       (bank_port.ram)
  );

  // Active bank steers register operand accesses
  assign bank_port.bank  = state.bank_select_pointer[4:0];
  assign bank_port.idx   = gp_idx_in;
  assign bank_port.we    = gp_we_in;
  assign bank_port.wdata = gp_wdata_in;

  // ALU result and flag terms
  logic [16:0] sum;
  logic [15:0] res;
  logic [15:0] opa;
  logic [15:0] opb;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;
  logic        carry;
  logic        ovf;
  logic        sub_op;
  logic        shift_op;
  logic [1:0]  il;

  always_comb begin
    opa      = alu_word_in ? state.acc : {8'h00, state.acc[7:0]};
    opb      = alu_word_in ? state.tmp : {8'h00, state.tmp[7:0]};
    sub_op   = (alu_op_in == 3'(cpu_regs_pkg::ALU_SUB));
    shift_op = (alu_op_in == 3'(cpu_regs_pkg::ALU_SHL)) ||
               (alu_op_in == 3'(cpu_regs_pkg::ALU_SHR));
    sum      = '0;
    res      = opa;
    carry    = 1'b0;
    case (alu_op_in)
      3'(cpu_regs_pkg::ALU_ADD): begin
        sum = {1'b0, opa} + {1'b0, opb};
        res = sum[15:0];
      end
      3'(cpu_regs_pkg::ALU_SUB): begin
        sum = {1'b0, opa} - {1'b0, opb};
        res = sum[15:0];
      end
      3'(cpu_regs_pkg::ALU_SHL): begin
        res   = {opa[14:0], 1'b0};
        carry = alu_word_in ? opa[15] : opa[7];
      end
      3'(cpu_regs_pkg::ALU_SHR): begin
        res   = {1'b0, opa[15:1]};
        carry = opa[0];
      end
      default: begin
        res = opa;
      end
    endcase
    if (!alu_word_in) begin
      res[15:8] = 8'h00;
    end
    // Carry out of bit 7 for bytes, of bit 15 for words
    if (!shift_op && alu_op_in != 3'(cpu_regs_pkg::ALU_PASS)) begin
      carry = alu_word_in ? sum[16] : (opa[8] ^ opb[8] ^ sum[8]);
    end
    msb_a = alu_word_in ? opa[15] : opa[7];
    msb_b = alu_word_in ? opb[15] : opb[7];
    msb_r = alu_word_in ? res[15] : res[7];
    ovf   = sub_op ? ((msb_a != msb_b) && (msb_r != msb_a))
                   : ((msb_a == msb_b) && (msb_r != msb_a));
    if (shift_op || alu_op_in == 3'(cpu_regs_pkg::ALU_PASS)) begin
      ovf = 1'b0;
    end
  end

  // Threshold code: 00 highest rank, 11 lowest
  assign il = {state.condition_flags_byte[cpu_regs_pkg::FLAG_IL1],
               state.condition_flags_byte[cpu_regs_pkg::FLAG_IL0]};

  // Next state of all registers
  always_comb begin
    logic        bus_wr;
    logic        setup;
    logic [15:0] wv;
    next_state = state;
    setup  = psel_in && !penable_in;
    bus_wr = psel_in && penable_in && state.pready && pwrite_in;
    wv     = pwdata_in[15:0];

    // APB writes take effect in the access cycle
    if (bus_wr) begin
      case (paddr_in)
        cpu_regs_pkg::OFS_PC:    next_state.pc = wv;
        cpu_regs_pkg::OFS_ACC:   next_state.acc = wv;
        cpu_regs_pkg::OFS_TMP:   next_state.tmp = wv;
        cpu_regs_pkg::OFS_INDEX: next_state.index_offset_reg = wv;
        cpu_regs_pkg::OFS_EXTRA: next_state.extra_pointer = wv;
        cpu_regs_pkg::OFS_STACK: next_state.stack = wv;
        cpu_regs_pkg::OFS_PSW: begin
          next_state.bank_select_pointer  = wv[15:8];
          next_state.condition_flags_byte = wv[7:0];
        end
        default: ;
      endcase
    end

    // Sequencer writes win over the bus
    if (pc_inc_in) begin
      next_state.pc = state.pc + 16'h0001;
    end
    if (seq_wr_in) begin
      case (seq_sel_in)
        3'(cpu_regs_pkg::SEL_PC):    next_state.pc = seq_wdata_in;
        3'(cpu_regs_pkg::SEL_ACC):   next_state.acc = seq_wdata_in;
        3'(cpu_regs_pkg::SEL_TMP):   next_state.tmp = seq_wdata_in;
        3'(cpu_regs_pkg::SEL_INDEX): next_state.index_offset_reg = seq_wdata_in;
        3'(cpu_regs_pkg::SEL_EXTRA): next_state.extra_pointer = seq_wdata_in;
        3'(cpu_regs_pkg::SEL_STACK): next_state.stack = seq_wdata_in;
        3'(cpu_regs_pkg::SEL_PSW): begin
          next_state.bank_select_pointer  = seq_wdata_in[15:8];
          next_state.condition_flags_byte = seq_wdata_in[7:0];
        end
        default: ;
      endcase
    end

    // ALU result to accumulator, byte ops keep the upper byte
    if (alu_valid_in) begin
      if (alu_word_in) begin
        next_state.acc = res;
      end else begin
        next_state.acc = {state.acc[15:8], res[7:0]};
      end
      // Half carry only for add and subtract, clear for shift and pass
      next_state.condition_flags_byte[cpu_regs_pkg::FLAG_H] =
        (opa[4] ^ opb[4] ^ sum[4]) &&
        (alu_op_in <= 3'(cpu_regs_pkg::ALU_SUB));
      next_state.condition_flags_byte[cpu_regs_pkg::FLAG_N] = msb_r;
      next_state.condition_flags_byte[cpu_regs_pkg::FLAG_Z] =
        (res == 16'h0000);
      next_state.condition_flags_byte[cpu_regs_pkg::FLAG_V] = ovf;
      next_state.condition_flags_byte[cpu_regs_pkg::FLAG_C] = carry;
    end

    // Request serviced only when enabled and ranking above threshold
    next_state.irq_accept = irq_req_in &&
      state.condition_flags_byte[cpu_regs_pkg::FLAG_I] &&
      (irq_level_in < il);

    // Region of the presented address
    if (mem_addr_in <= cpu_regs_pkg::IO_TOP) begin
      next_state.region = 2'(cpu_regs_pkg::REGION_IO);
    end else if (mem_addr_in <= cpu_regs_pkg::DATA_TOP) begin
      next_state.region = 2'(cpu_regs_pkg::REGION_DATA);
    end else begin
      next_state.region = 2'(cpu_regs_pkg::REGION_PROG);
    end

    // APB answer prepared in setup, shown in access
    next_state.pready  = setup;
    next_state.pslverr = 1'b0;
    next_state.prdata  = 32'h0000_0000;
    if (setup) begin
      case (paddr_in)
        cpu_regs_pkg::OFS_PC:    next_state.prdata = {16'h0000, state.pc};
        cpu_regs_pkg::OFS_ACC:   next_state.prdata = {16'h0000, state.acc};
        cpu_regs_pkg::OFS_TMP:   next_state.prdata = {16'h0000, state.tmp};
        cpu_regs_pkg::OFS_INDEX:
          next_state.prdata = {16'h0000, state.index_offset_reg};
        cpu_regs_pkg::OFS_EXTRA:
          next_state.prdata = {16'h0000, state.extra_pointer};
        cpu_regs_pkg::OFS_STACK: next_state.prdata = {16'h0000, state.stack};
        cpu_regs_pkg::OFS_PSW:
          next_state.prdata = {16'h0000, state.bank_select_pointer,
                               state.condition_flags_byte};
        cpu_regs_pkg::OFS_STATUS:
          next_state.prdata = {29'h0000_0000, state.region,
                               state.irq_accept};
        default: next_state.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state                      <= '0;
      state.pc                   <= cpu_regs_pkg::WORD_RESET;
      state.bank_select_pointer  <= cpu_regs_pkg::PSW_RESET[15:8];
      state.condition_flags_byte <= cpu_regs_pkg::PSW_RESET[7:0];
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register; gp_rdata_out from the bank RAM read register
  assign prdata_out              = state.prdata;
  assign pready_out              = state.pready;
  assign pslverr_out             = state.pslverr;
  assign irq_accept_out          = state.irq_accept;
  assign mem_region_out          = state.region;
  assign pc_out                  = state.pc;
  assign acc_out                 = state.acc;
  assign program_status_word_out = {state.bank_select_pointer,
                                    state.condition_flags_byte};
  assign gp_rdata_out            = bank_port.rdata;

endmodule : cpu_register_flags

// file: common/cpu_regs_pkg.sv
/*
  Constants shared by the dedicated register set, its flag logic and the
  general-purpose register banks.
  Assumes one clock domain and an APB master that uses 32-bit aligned words.
*/
// Behaviour
// - One unified 64 Kbyte space holds I/O, data and program regions.
// - I/O sits lowest; data region directly above it, split as software likes.
// - Program counter is a 16-bit register pointing at the fetched instruction.
// - Accumulator is 16 bits; byte instructions use its lower byte only.
// - Temporary accumulator is 16 bits, partner operand; byte ops use low byte.
// - Index register, extra pointer and stack pointer are each 16 bits.
// - Status word: upper byte bank pointer, lower byte condition flags.
// - Half-carry set on carry or borrow between bit 3 and bit 4.
// - Interrupt enable flag allows interrupts when 1; reset clears it.
// - Two-bit threshold; only requests ranking above it are serviced.
// - Negative flag copies the most significant bit of the result.
// - Zero flag set for a zero result, cleared otherwise.
// - Overflow flag set on two's-complement overflow, cleared otherwise.
// - Carry set on carry or borrow out of bit 7; shifts load shifted bit. Word ops use bit 15.
// - General registers are 8-bit RAM bytes, eight per bank, 32 banks.
// - Bank pointer selects the active bank for register operand accesses.
package cpu_regs_pkg;

  // Memory map
  localparam int          ADDR_W       = 16;
  localparam logic [15:0] IO_TOP       = 16'h007f;
  localparam logic [15:0] DATA_TOP     = 16'h027f;
  localparam int          RAM_BYTES    = 512;
  localparam int          BANK_REGS    = 8;
  localparam int          BANK_COUNT   = 32;

  typedef enum logic [1:0] {
    REGION_IO, REGION_DATA, REGION_PROG
  } region_t;

  // APB register byte offsets
  localparam logic [7:0] OFS_PC     = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_TMP    = 8'h08;
  localparam logic [7:0] OFS_INDEX  = 8'h0c;
  localparam logic [7:0] OFS_EXTRA  = 8'h10;
  localparam logic [7:0] OFS_STACK  = 8'h14;
  localparam logic [7:0] OFS_PSW    = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Condition flag byte field positions
  localparam int FLAG_H   = 7;
  localparam int FLAG_I   = 6;
  localparam int FLAG_IL1 = 5;
  localparam int FLAG_IL0 = 4;
  localparam int FLAG_N   = 3;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_V   = 1;
  localparam int FLAG_C   = 0;

  // Reset values
  localparam logic [15:0] PSW_RESET   = 16'h0030;
  localparam logic [15:0] WORD_RESET  = 16'h0000;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_SHL, ALU_SHR, ALU_PASS
  } alu_op_t;

  typedef enum logic [2:0] {
    SEL_PC, SEL_ACC, SEL_TMP, SEL_INDEX, SEL_EXTRA, SEL_STACK, SEL_PSW
  } reg_sel_t;

endpackage : cpu_regs_pkg

// file: common/gp_bank_if.sv
/*
  Carrier between the register core and the general-purpose bank RAM.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface gp_bank_if;
  logic [4:0] bank;
  logic [2:0] idx;
  logic       we;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport core (output bank, output idx, output we, output wdata,
                input rdata);
  modport ram  (input bank, input idx, input we, input wdata,
                output rdata);
endinterface : gp_bank_if

// file: hw/gp_bank_ram.sv
/*
  General-purpose register banks held in RAM, eight bytes per bank.
  Assumes a synchronous read; data appears one cycle after the request.
*/
`timescale 1ns/1ns
module gp_bank_ram #(
  parameter int RAM_BYTES = cpu_regs_pkg::RAM_BYTES
) (
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  gp_bank_if.ram    port
);
  localparam int AW = $clog2(RAM_BYTES);

  typedef struct packed {
    logic [7:0] rdata;
  } ram_state_t;

  logic [7:0] mem [RAM_BYTES];
  ram_state_t state;
  ram_state_t next_state;
  logic [AW-1:0] byte_addr;

  // Bank base is bank number times eight
  assign byte_addr = AW'({port.bank, port.idx});

  always_comb begin
    next_state       = state;
    next_state.rdata = mem[byte_addr];
  end

  // Storage and read register
  always_ff @(posedge sys_clk_in) begin
    if (port.we) begin
      mem[byte_addr] <= port.wdata;
    end
    if (srst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign port.rdata = state.rdata;
endmodule : gp_bank_ram

// file: dv/alu_drv.sv
/* Stand-in for the ALU sequencer: one operation strobe per request.
   Assumes the core samples the strobe and its qualifiers together. */
`timescale 1ns/1ns
module alu_drv (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       slow_in,
  input  wire logic [2:0] op_in,
  input  wire logic       word_in,
  output logic            valid_out,
  output logic      [2:0] op_out,
  output logic            word_out
);
  logic pend;
  initial begin
    pend = 1'b0;
    valid_out = 1'b0;
    op_out = 3'h0;
    word_out = 1'b0;
  end
  // One-cycle strobe, one cycle late when slow; idle lines keep changing
  always @(posedge clk_in) begin
    pend <= go_in & slow_in;
    valid_out <= (go_in & ~slow_in) | pend;
    op_out <= (go_in | pend) ? op_in : ~op_out;
    word_out <= (go_in | pend) ? word_in : ~word_out;
  end
endmodule : alu_drv

// file: dv/cpu_register_flags_sva.sv
/* Port-level checker for the register core.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ns
module cpu_register_flags_sva (
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic        alu_valid_in,
  input wire logic [2:0]  alu_op_in,
  input wire logic        alu_word_in,
  input wire logic        seq_wr_in,
  input wire logic        pc_inc_in,
  input wire logic        irq_req_in,
  input wire logic [1:0]  irq_level_in,
  input wire logic        irq_accept_out,
  input wire logic [15:0] mem_addr_in,
  input wire logic [1:0]  mem_region_out,
  input wire logic [15:0] pc_out,
  input wire logic [15:0] acc_out,
  input wire logic [15:0] program_status_word_out
);
  wire logic [15:0] psw = program_status_word_out;
  wire logic        apb_wr = psel_in && penable_in && pwrite_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_irq_gate: assert property (!$past(srst_in) |-> irq_accept_out ==
    $past(irq_req_in && psw[6] && irq_level_in < psw[5:4]))
    else $error("interrupt accept wrong");
  a_region_map: assert property (!$past(srst_in) |-> mem_region_out ==
    ($past(mem_addr_in) <= 16'h007f ? 2'h0 :
     $past(mem_addr_in) <= 16'h027f ? 2'h1 : 2'h2))
    else $error("region decode wrong");
  a_pc_step: assert property (pc_inc_in && !seq_wr_in && !apb_wr
    |=> pc_out == $past(pc_out) + 16'h0001) else $error("pc step wrong");
  a_zero_flag: assert property (alu_valid_in && alu_op_in < 3'd4
    |=> psw[2] == ($past(alu_word_in) ? acc_out == 16'h0000
                                      : acc_out[7:0] == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (alu_valid_in && alu_op_in < 3'd4
    |=> psw[3] == ($past(alu_word_in) ? acc_out[15] : acc_out[7]))
    else $error("negative flag wrong");
  a_byte_upper: assert property (alu_valid_in && !alu_word_in
    |=> acc_out[15:8] == $past(acc_out[15:8])) else $error("acc hi changed");
  a_shift_flags: assert property (alu_valid_in &&
    alu_op_in inside {3'd2, 3'd3} |=> !psw[1] && !psw[7])
    else $error("shift flags wrong");
  a_shl_carry: assert property (alu_valid_in && alu_op_in == 3'd2
    |=> psw[0] == $past(alu_word_in ? acc_out[15] : acc_out[7]))
    else $error("shift carry wrong");
  a_bank_hold: assert property (!seq_wr_in && !apb_wr
    |=> $stable(psw[15:8])) else $error("bank pointer moved");
endmodule : cpu_register_flags_sva

bind cpu_register_flags cpu_register_flags_sva chk_u (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in),
  .alu_valid_in(alu_valid_in), .alu_op_in(alu_op_in),
  .alu_word_in(alu_word_in), .seq_wr_in(seq_wr_in), .pc_inc_in(pc_inc_in),
  .irq_req_in(irq_req_in), .irq_level_in(irq_level_in),
  .irq_accept_out(irq_accept_out), .mem_addr_in(mem_addr_in),
  .mem_region_out(mem_region_out), .pc_out(pc_out), .acc_out(acc_out),
  .program_status_word_out(program_status_word_out));

// file: dv/cpu_register_flags_tb.sv
/* Bench for the register core: APB reads and bank bytes checked against
   queued expectations. Assumes the checker binds itself. */
`timescale 1ns/1ns
module cpu_register_flags_tb;
  logic        clk = 1'b0, rst = 1'b1, psel, pen, pwr, pc_inc, gp_we;
  logic        irq_req, go, slow, word, gp_chk, gp_chk_d, a_val, a_word;
  logic [7:0]  paddr, gp_wdata, gp_rd;
  logic [31:0] pwdata, prdata;
  logic [2:0]  op, gp_idx, a_op;
  logic [1:0]  irq_lvl;
  logic [15:0] maddr;
  logic        seq_wr;
  logic [2:0]  seq_sel;
  logic [15:0] seq_wdata;
  logic        pready, pslverr, irq_acc;
  logic [33:0] q[$];
  logic [7:0]  gq[$];
  int          failures, n_checks;

  always #5 clk = ~clk;

  cpu_register_flags dut_u (
    .sys_clk_in(clk), .srst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .alu_valid_in(a_val), .alu_op_in(a_op), .alu_word_in(a_word),
    .seq_wr_in(seq_wr), .seq_sel_in(seq_sel), .seq_wdata_in(seq_wdata),
    .pc_inc_in(pc_inc), .gp_idx_in(gp_idx), .gp_we_in(gp_we),
    .gp_wdata_in(gp_wdata), .gp_rdata_out(gp_rd), .irq_req_in(irq_req),
    .irq_level_in(irq_lvl), .irq_accept_out(irq_acc),
    .mem_addr_in(maddr), .mem_region_out(), .pc_out(), .acc_out(),
    .program_status_word_out());
  alu_drv alu_u (.clk_in(clk), .go_in(go), .slow_in(slow), .op_in(op),
    .word_in(word), .valid_out(a_val), .op_out(a_op), .word_out(a_word));

  task automatic fail(input string m);
    failures++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // One APB transfer; e = {is_write, error, data}
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    @(posedge clk);
    q.push_back(e);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin fail("no ready"); wrap_up(); end
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'($urandom), d}, {2'b10, 32'h0});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, $urandom, {2'b00, 16'h0000, e});
  endtask : rd

  // Select a bank, then write or check one register byte in it
  task automatic gp(input logic w, input logic [4:0] b, input logic [7:0] d);
    wr(8'h18, {3'($urandom), b, 8'h30});
    @(posedge clk);
    gp_idx <= 3'h5; gp_wdata <= d; gp_we <= w; gp_chk <= !w;
    if (!w) gq.push_back(d);
    @(posedge clk);
    gp_we <= 1'b0; gp_chk <= 1'b0;
    @(posedge clk);
  endtask : gp

  // Reference result and flags {res, h, n, z, v, c}
  function automatic logic [20:0] alu_ref(input logic [2:0] o,
    input logic w, input logic [15:0] a, input logic [15:0] t);
    logic [16:0] r, x, y; logic h, v; int m;
    m = w ? 15 : 7;
    x = w ? {1'b0, a} : {9'h0, a[7:0]};
    y = w ? {1'b0, t} : {9'h0, t[7:0]};
    h = 1'b0; v = 1'b0;
    case (o)
      3'd0: begin r = x + y; h = (a[3:0] + t[3:0]) > 5'd15; end
      3'd1: begin r = x - y; h = a[3:0] < t[3:0]; end
      3'd2: r = x << 1;
      3'd3: r = x >> 1;
      default: r = x;
    endcase
    if (o < 3'd2) v = ((a[m] ^ t[m]) == o[0]) && (r[m] != a[m]);
    return {w ? r[15:0] : {a[15:8], r[7:0]}, h, r[m],
            w ? r[15:0] == 0 : r[7:0] == 0, v, o == 3'd3 ? x[0] : r[m+1]};
  endfunction : alu_ref

  // Compare each result as it appears against the oldest note
  always @(posedge clk) begin
    logic [33:0] e;
    gp_chk_d <= gp_chk;
    if (psel && pen && pready) begin
      e = q.pop_front();
      n_checks++;
      if (pslverr !== e[32] || (!e[33] && prdata !== e[31:0]))
        fail("apb answer mismatch");
    end
    if (gp_chk_d) begin
      n_checks++;
      if (gp_rd !== gq.pop_front()) fail("bank byte mismatch");
    end
  end

  initial begin
    logic [15:0] a, t, p, at[6];
    logic [20:0] r;
    logic [7:0]  bd[4];
    {psel, pen, pwr, pc_inc, gp_we, irq_req, go, slow, word} = '0;
    {gp_chk, gp_chk_d, paddr, pwdata, op, gp_idx, gp_wdata} = '0;
    irq_lvl = 2'h0; maddr = 16'h0000; failures = 0; n_checks = 0;
    seq_wr = 1'b0;
    seq_sel = 3'h0;
    seq_wdata = 16'h0000;
    at = '{16'h0000, 16'h007f, 16'h0080, 16'h027f, 16'h0280, 16'hffff};
    void'($urandom(32'hb17feae1));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h18, 16'h0030);
    rd(8'h04, 16'h0000);
    apb(1'b0, 8'h20, 32'h0, {2'b01, 32'h0});
    apb(1'b1, 8'h40, $urandom, {2'b11, 32'h0});
    for (int i = 0; i < 7; i++) begin
      a = $urandom;
      wr(8'(4 * i), a);
      rd(8'(4 * i), a);
    end
    // Sequencer loads each register, read back over the bus
    for (int i = 0; i < 7; i++) begin
      a = $urandom;
      seq_sel <= 3'(i);
      seq_wdata <= a;
      seq_wr <= 1'b1;
      @(posedge clk);
      seq_wr <= 1'b0;
      rd(8'(4 * i), a);
    end
    wr(8'h00, 16'hffff);
    pc_inc <= 1'b1;
    @(posedge clk);
    pc_inc <= 1'b0;
    rd(8'h00, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      a = $urandom; t = $urandom; p = $urandom;
      wr(8'h04, a); wr(8'h08, t); wr(8'h18, p);
      r = alu_ref(3'(i % 5), i[2], a, t);
      op <= 3'(i % 5); word <= i[2]; slow <= i[3]; go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int n = 0; n < 4 && a_val !== 1'b1; n++) @(posedge clk);
      if (a_val !== 1'b1) begin fail("no strobe"); wrap_up(); end
      rd(8'h04, r[20:5]);
      rd(8'h18, {p[15:8], r[4], p[6:4], r[3:0]});
    end
    for (int k = 0; k < 4; k++) begin
      bd[k] = $urandom;
      gp(1'b1, 5'(k * 10 + 1), bd[k]);
    end
    for (int k = 3; k >= 0; k--) gp(1'b0, 5'(k * 10 + 1), bd[k]);
    for (int k = 0; k < 6; k++) begin
      maddr <= at[k];
      rd(8'h1c, {13'h0, 2'(k / 2), 1'b0});
    end
    for (int k = 0; k < 64; k++) begin
      irq_req <= k[5]; irq_lvl <= k[1:0];
      wr(8'h18, {8'h00, 1'b0, k[4], k[3:2], 4'h0});
      rd(8'h1c, {13'h0, 2'h2, k[5] & k[4] & (k[1:0] < k[3:2])});
    end
    // Mid-run reset with interrupts enabled and a request pending
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h18, 16'h0030);
    rd(8'h1c, 16'h0004);
    wrap_up();
  end
endmodule : cpu_register_flags_tb
